// [logic/rtc_pkg.sv]
// Shared constants and types of the seconds clock with alarm
package rtc_pkg;

  localparam logic [15:0] OFS_TOKEN = 16'h4020;
  localparam logic [15:0] OFS_SECS_HI = 16'h4021;
  localparam logic [15:0] OFS_SECS_LO = 16'h4022;
  localparam logic [15:0] OFS_ALARM_HI = 16'h4023;
  localparam logic [15:0] OFS_ALARM_LO = 16'h4024;
  localparam logic [15:0] OFS_CTRL = 16'h4025;

  localparam int BIT_VALID = 15;
  localparam int BIT_BUSY = 14;
  localparam int BIT_ALARM_EN = 10;
  localparam int POS_PERIOD = 4;

  localparam logic [31:0] SECS_RESET = 32'h0000_0000;
  localparam logic [31:0] ALARM_RESET = 32'h0000_0000;
  localparam logic [2:0] PERIOD_RESET = 3'h0;
  localparam logic [15:0] TOKEN_SEED = 16'hACE1;
  localparam logic [15:0] TOKEN_TAPS = 16'hB400;

  localparam int CLK_PERIOD_NS = 20;
  localparam int SECOND_NS = 1000000000;
  localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int SYNC_NS = 60;
  localparam logic [1:0] SYNC_CYCLES = 2'(SYNC_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic alarm;
    logic periodic;
  } rtc_events_t;

endpackage

// [logic/second_tick.sv]
// Divides the system clock down to a one-per-second tick
`timescale 1ns/1ps
module second_tick #(
  parameter int CYCLES = rtc_pkg::SEC_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic restart_in,
  output logic tick_out
);
  typedef struct packed {
    logic [25:0] cnt;
    logic tick;
  } tick_state_t;

  tick_state_t s_ff;
  tick_state_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (restart_in) begin
      // A fresh time starts a full second, not a leftover fraction
      nxt_s.cnt = '0;
    end else if (s_ff.cnt == 26'(CYCLES - 1)) begin
      nxt_s.cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 26'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_ff <= '0;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign tick_out = s_ff.tick;
endmodule // second_tick

// [logic/token_lfsr.sv]
// Sixteen-bit Galois shift register for the write-change token
`timescale 1ns/1ps
module token_lfsr (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic step_in,
  output logic [15:0] value_out
);
  typedef struct packed {
    logic [15:0] val;
  } lfsr_state_t;

  lfsr_state_t s_ff;
  lfsr_state_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (step_in) begin
      // Nonzero seed and maximal taps keep it from locking at zero
      nxt_s.val = {1'b0, s_ff.val[15:1]} ^
                  (s_ff.val[0] ? rtc_pkg::TOKEN_TAPS : 16'h0000);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_ff.val <= rtc_pkg::TOKEN_SEED;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign value_out = s_ff.val;
endmodule // token_lfsr

// [logic/seconds_rtc.sv]
// Seconds counter with alarm, periodic event and write-change token
`timescale 1ns/1ps
module seconds_rtc #(
  parameter int SEC_CYCLES = rtc_pkg::SEC_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire rtc_pkg::bus_req_t bus_in,
  output logic [15:0] rd_data_out,
  output rtc_pkg::rtc_events_t events_out
);
  typedef struct packed {
    logic [31:0] secs;
    logic [31:0] alarm;
    logic valid;
    logic [1:0] busy_cnt;
    logic alarm_en;
    logic [2:0] period;
    logic [15:0] rdata;
    rtc_pkg::rtc_events_t evt;
  } rtc_state_t;

  rtc_state_t s_ff;
  rtc_state_t nxt_s;
  logic tick;
  logic [15:0] token;
  logic time_wr;

  // Low bits that must be zero for a periodic event; zero code selects no bits
  function automatic logic [31:0] period_mask(input logic [2:0] code);
    period_mask = (32'h0000_0001 << code) - 32'h0000_0001;
  endfunction

  function automatic logic [15:0] ctrl_word(input rtc_state_t st);
    logic [15:0] w;
    w = 16'h0000;
    w[rtc_pkg::BIT_VALID] = st.valid;
    w[rtc_pkg::BIT_BUSY] = (st.busy_cnt != 2'h0);
    w[rtc_pkg::BIT_ALARM_EN] = st.alarm_en;
    w[rtc_pkg::POS_PERIOD +: 3] = st.period;
    ctrl_word = w;
  endfunction

  assign time_wr = bus_in.wr && (bus_in.addr == rtc_pkg::OFS_SECS_HI ||
                   bus_in.addr == rtc_pkg::OFS_SECS_LO);

  second_tick #(
    .CYCLES(SEC_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .restart_in(time_wr),
    .tick_out(tick)
  );

  token_lfsr u_token (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .step_in(time_wr),
    .value_out(token)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.evt = '0;
    nxt_s.rdata = 16'h0000;
    if (s_ff.busy_cnt != 2'h0) begin
      nxt_s.busy_cnt = s_ff.busy_cnt - 2'h1;
    end
    if (tick) begin
      nxt_s.secs = s_ff.secs + 32'h0000_0001;
      nxt_s.evt.alarm = s_ff.alarm_en && (nxt_s.secs == s_ff.alarm);
      nxt_s.evt.periodic = (s_ff.period != 3'h0) &&
        ((nxt_s.secs & period_mask(s_ff.period)) == 32'h0000_0000);
    end
    // A write lands after the tick, so software's value wins
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        rtc_pkg::OFS_SECS_HI: begin
          nxt_s.secs[31:16] = bus_in.wdata;
          nxt_s.valid = 1'b1;
          nxt_s.busy_cnt = rtc_pkg::SYNC_CYCLES;
        end
        rtc_pkg::OFS_SECS_LO: begin
          nxt_s.secs[15:0] = bus_in.wdata;
          nxt_s.valid = 1'b1;
          nxt_s.busy_cnt = rtc_pkg::SYNC_CYCLES;
        end
        rtc_pkg::OFS_ALARM_HI: begin
          nxt_s.alarm[31:16] = bus_in.wdata;
          nxt_s.busy_cnt = rtc_pkg::SYNC_CYCLES;
        end
        rtc_pkg::OFS_ALARM_LO: begin
          nxt_s.alarm[15:0] = bus_in.wdata;
          nxt_s.busy_cnt = rtc_pkg::SYNC_CYCLES;
        end
        rtc_pkg::OFS_CTRL: begin
          nxt_s.alarm_en = bus_in.wdata[rtc_pkg::BIT_ALARM_EN];
          nxt_s.period = bus_in.wdata[rtc_pkg::POS_PERIOD +: 3];
          nxt_s.busy_cnt = rtc_pkg::SYNC_CYCLES;
        end
        default: begin
        end
      endcase
    end
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        rtc_pkg::OFS_TOKEN: nxt_s.rdata = token;
        rtc_pkg::OFS_SECS_HI: nxt_s.rdata = s_ff.secs[31:16];
        rtc_pkg::OFS_SECS_LO: nxt_s.rdata = s_ff.secs[15:0];
        rtc_pkg::OFS_ALARM_HI: nxt_s.rdata = s_ff.alarm[31:16];
        rtc_pkg::OFS_ALARM_LO: nxt_s.rdata = s_ff.alarm[15:0];
        rtc_pkg::OFS_CTRL: nxt_s.rdata = ctrl_word(s_ff);
        default: nxt_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_ff <= '0;
      s_ff.secs <= rtc_pkg::SECS_RESET;
      s_ff.alarm <= rtc_pkg::ALARM_RESET;
      s_ff.period <= rtc_pkg::PERIOD_RESET;
      s_ff.valid <= 1'b0;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign rd_data_out = s_ff.rdata;
  assign events_out = s_ff.evt;
endmodule // seconds_rtc

// [testbench/seconds_rtc_assertions.sv]
// Checker of bus timing and event gating of the seconds clock
`timescale 1ns/1ps
module seconds_rtc_assertions #(parameter int SEC_CYCLES = 8) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire rtc_pkg::bus_req_t bus_in,
  input wire logic [15:0] rd_data_out,
  input wire rtc_pkg::rtc_events_t events_out
);
  wire [15:0] a = bus_in.addr;
  wire w = bus_in.wr;
  wire r = bus_in.rd;
  logic en_ff;
  logic [2:0] per_ff;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Shadow of the gating fields; an edge that writes them still uses old ones
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      en_ff <= 1'h0;
      per_ff <= 3'h0;
    end else if (w && a == 16'h4025) begin
      en_ff <= bus_in.wdata[10];
      per_ff <= bus_in.wdata[6:4];
    end
  end
  AST_RD_SLOT: assert property (!$past(r) |-> rd_data_out == 16'h0)
    else $error("read data outside slot");
  AST_RST: assert property ($rose(rst_b_in) |-> events_out == 2'h0)
    else $error("event at reset release");
  AST_VALID_BUSY: assert property (w && a == 16'h4022 ##1 r &&
    a == 16'h4025 |=> rd_data_out[15:14] == 2'h3) else $error("status");
  AST_SECS_RB: assert property (w && a == 16'h4022 ##1 r &&
    a == 16'h4022 |=> rd_data_out == $past(bus_in.wdata, 2))
    else $error("seconds readback");
  AST_ALM_RB: assert property (w && a == 16'h4023 ##1 r &&
    a == 16'h4023 |=> rd_data_out == $past(bus_in.wdata, 2))
    else $error("alarm readback");
  AST_ALM_EN: assert property (events_out.alarm |-> $past(en_ff))
    else $error("alarm while disabled");
  AST_PER_OFF: assert property (events_out.periodic |->
    $past(per_ff) != 3'h0) else $error("periodic while disabled");
  AST_PER_GAP: assert property (events_out.periodic |=>
    !events_out.periodic [*7]) else $error("periodic too close");
endmodule // seconds_rtc_assertions

bind seconds_rtc seconds_rtc_assertions #(.SEC_CYCLES(SEC_CYCLES)) i_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in),
  .rd_data_out(rd_data_out), .events_out(events_out));

// [testbench/tb_top.sv]
// Self-checking bench of the seconds clock block
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 1'h0;
  logic ce = 1'h1;
  logic rst_b_in = 1'h0;
  rtc_pkg::bus_req_t b = '0;
  logic [15:0] rd;
  rtc_pkg::rtc_events_t ev;
  logic [15:0] tok = 16'hACE1;
  int fails = 0;
  int comparisons = 0;
  int n;
  // Short second keeps the 128 s period case within a few thousand cycles
  seconds_rtc #(.SEC_CYCLES(8)) i_dut (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .ce_in(ce), .bus_in(b), .rd_data_out(rd),
    .events_out(ev));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic op(input logic [1:0] k, input logic [15:0] a, d);
    @(posedge clk_in);
    b <= '{a, d, k[1], k[0]};
  endtask
  task automatic wr(input logic [15:0] a, d);
    op(2'h2, a, d);
    if (a == 16'h4021 || a == 16'h4022) begin
      tok = {1'h0, tok[15:1]} ^ (tok[0] ? 16'hB400 : 16'h0000);
    end
  endtask
  task automatic cmp(input string s, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdc(input logic [15:0] a, e);
    op(2'h1, a, 16'h0000);
    op(2'h0, 16'h0000, 16'h0000);
    @(negedge clk_in);
    cmp("rd_data", e, rd);
  endtask
  // Counts falling edges until an event shows, giving up after 40
  task automatic waitev();
    // A write strobe must not stay high while waiting
    op(2'h0, 16'h0000, 16'h0000);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (ev === 2'h0 && n < 40);
  endtask
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'h1;
    rdc(16'h4025, 16'h0000);
    wr(16'h4020, 16'h1234);
    rdc(16'h4020, tok);
    rdc(16'h4026, 16'h0000);
    wr(16'h4025, 16'h0410);
    wr(16'h4023, 16'h0001);
    rdc(16'h4023, 16'h0001);
    wr(16'h4024, 16'h0001);
    wr(16'h4021, 16'h0000);
    wr(16'h4022, 16'hFFFF);
    rdc(16'h4025, 16'hC410);
    waitev();
    cmp("events", 16'h0001, {14'h0, ev});
    waitev();
    cmp("events", 16'h0002, {14'h0, ev});
    cmp("tick_gap", 16'h0008, 16'(n));
    rdc(16'h4021, 16'h0001);
    rdc(16'h4024, 16'h0001);
    for (int c = 0; c < 8; c++) begin
      wr(16'h4021, 16'h0000);
      wr(16'h4022, (16'h0001 << c) - 16'h0002);
      rdc(16'h4022, (16'h0001 << c) - 16'h0002);
      wr(16'h4025, 16'(c << 4));
      waitev();
      cmp("events", {15'h0, c != 0}, {14'h0, ev});
      cmp("event_wait", 16'h0001, {15'h0, c == 0 || (n > 12 && n < 20)});
      rdc(16'h4025, 16'h8000 | 16'(c << 4));
    end
    // Frozen clock enable must swallow a time write
    @(posedge clk_in);
    ce <= 1'h0;
    op(2'h2, 16'h4021, 16'h5555);
    op(2'h0, 16'h0000, 16'h0000);
    @(posedge clk_in);
    ce <= 1'h1;
    rdc(16'h4020, tok);
    rdc(16'h4021, 16'h0000);
    end_sim();
  end
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule // tb_top
